// ### core/bcs_boot_setup.sv
// Operation
// R1 - grounded strap external resonator, open internal
// R2 - frequency straps pick default PLL band settings
// R3 - tile clock from F, R, output divider
// R4 - software keeps divider fields within range
// R5 - software may rewrite PLL fields anytime; pll_wr is ignored while in st_strap
// R6 - board holds straps until third edge
// R7 - in reset all general pins undriven
// R8 - long internal reset, then pulls, then boot
// R9 - boot source strap decode table
// R10 - security bit five forces boot from OTP
// R11 - SPI boot enables pins, device is master
// R12 - SPI pin mapping fixed, not relocatable
// R13 - link B enabled after 200 ns
// R14 - partner holds incoming link wires low
// R15 - secure boot starts at OTP address zero
// R16 - debug port disable refuses tile access
// R17 - link disable blocks switch access
// R18 - global debug disable ignores debug pin
// R19 - master lock and four sector locks
// R20 - load security row, copy OTP first
// R21 - OTP is 2k rows of 32 bits
// R22 - straps latched once at third edge
`include "bcs_defines.svh"
module bcs_boot_setup
	import bcs_pkg::*;
#(
	parameter int unsigned RESET_CYCLES = `BCS_RESET_CYCLES,
	parameter int unsigned SPI_IMAGE_WORDS = `BCS_SPI_IMAGE_WORDS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic osc_ext_n_pin,
	input wire logic freq_strap_lo,
	input wire logic freq_strap_hi,
	input wire logic [2:0] boot_src_strap,
	output logic osc_sel_ext,
	output logic [11:0] pll_f,
	output logic [5:0] pll_r,
	output logic [2:0] pll_output_divider,
	input wire logic pll_wr,
	input wire logic [11:0] pll_wr_f,
	input wire logic [5:0] pll_wr_r,
	input wire logic [2:0] pll_wr_od,
	output logic gpio_pull_en,
	output logic otp_rd_en,
	output logic [10:0] otp_rd_addr,
	input wire logic [31:0] otp_rd_data,
	output logic sram_we,
	output logic [13:0] sram_waddr,
	output logic [31:0] sram_wdata,
	output logic [31:0] sec_reg,
	output logic exec_start,
	output logic exec_from_otp,
	output logic [10:0] exec_addr,
	input wire logic jtag_req,
	output logic jtag_grant,
	input wire logic sw_req,
	output logic sw_grant,
	input wire logic debug_n_pin,
	output logic debug_req,
	input wire logic otp_ext_req,
	input wire logic [10:0] otp_ext_addr,
	output logic otp_ext_grant,
	output logic otp_ext_deny,
	output logic spi_en,
	output logic spi_ss_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso,
	output logic spi_dual_tile,
	output logic link_b_en,
	output logic [1:0] link_out,
	output logic link_out_oe,
	output logic link_pd_en,
	input wire logic [1:0] link_in,
	output logic link_traffic,
	output logic int_links_en,
	output logic chan_boot
);
	localparam int P_OSC = 0;
	localparam int P_LO = 1;
	localparam int P_HI = 2;
	localparam int P_BOOT = 3;
	localparam int P_DBG = 6;
	localparam int P_MISO = 7;
	localparam int P_LINK = 8;
	localparam logic [13:0] SPI_LAST = 14'(`BCS_SPI_HDR_BYTES + 4 * SPI_IMAGE_WORDS - 1);

	function automatic logic otp_locked(input logic [31:0] sec, input logic [10:0] addr);
		otp_locked = sec[`BCS_SEC_MLOCK] | sec[`BCS_SEC_SLOCK_LSB + int'(addr[10:9])];
	endfunction : otp_locked

	bcs_state_type state, next_state;
	logic [9:0] pin_raw, sync1, sync2, sync3, pin_q;
	logic [1:0] strap_cnt;
	logic strap_osc;
	logic [2:0] strap_boot;
	logic [19:0] rst_cnt;
	logic [1:0] link_cnt;
	logic rd_vld;
	logic [10:0] rd_addr_d;
	logic spi_go, spi_fin;
	logic [13:0] spi_idx;
	logic [31:0] spi_word;
	logic [7:0] spi_rx;
	logic spi_done;

	// three-stage pin synchronisers, change taken when stages agree
	assign pin_raw = {link_in, spi_miso, debug_n_pin, boot_src_strap, freq_strap_hi, freq_strap_lo, osc_ext_n_pin};
	// no reset: held straps must reach stage three by the third edge
	always_ff @(posedge clock) begin
		if (ce) begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	generate
		for (genvar i = 0; i < 10; i++) begin : g_pin
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pin_q[i] <= 1'b0;
				end else if (ce && sync2[i] == sync3[i]) begin
					pin_q[i] <= sync3[i];
				end
			end
		end
	endgenerate

	// decode and sequencing
	wire strap_latch = (state == st_strap) && (strap_cnt == `BCS_STRAP_LATCH_EDGE); // [R6] [R22]
	wire [1:0] band = {sync3[P_HI], sync3[P_LO]};
	wire [11:0] def_f = (band == 2'd0) ? `BCS_F_B0 : (band == 2'd1) ? `BCS_F_B1 :
		(band == 2'd2) ? `BCS_F_B2 : `BCS_F_B3; // [R2]
	wire [2:0] def_od = (band == 2'd0) ? `BCS_OD_B0 : `BCS_OD_B123; // [R2]
	wire copy_last = (state == st_copy) && rd_vld && (rd_addr_d == `BCS_OTP_SEC_ROW - 11'h001); // [R20]
	wire boot_live = !(state inside {st_strap, st_ireset, st_sec_rd, st_copy});
	wire ext_lock = otp_locked(sec_reg, otp_ext_addr); // [R19]
	wire spi_hdr = (spi_idx < 14'(`BCS_SPI_HDR_BYTES));
	wire [13:0] spi_widx = spi_idx - 14'(`BCS_SPI_HDR_BYTES);
	bcs_state_type boot_pick;
	assign boot_pick = sec_reg[`BCS_SEC_SECURE] ? st_otp_exec : // [R10]
		(strap_boot[1:0] == 2'b00) ? st_jtag_wait :
		(strap_boot[1:0] == 2'b01) ? st_rsvd :
		strap_boot[0] ? st_spi_run : st_link_dly; // [R9]

	always_comb begin
		next_state = state;
		unique case (state)
			st_strap: if (strap_latch) next_state = st_ireset;
			st_ireset: if (rst_cnt == 20'h00000) next_state = st_sec_rd; // [R8]
			st_sec_rd: if (rd_vld) next_state = st_copy; // [R20]
			st_copy: if (copy_last) next_state = boot_pick;
			st_link_dly: if (link_cnt == 2'h0) next_state = st_link_run;
			st_jtag_wait, st_rsvd, st_link_run, st_spi_run, st_otp_exec: next_state = state;
			default: next_state = st_strap;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_strap;
			strap_cnt <= 2'h0;
			strap_osc <= 1'b1;
			strap_boot <= 3'h0;
			rst_cnt <= 20'h00000;
			link_cnt <= 2'h0;
		end else if (ce) begin
			state <= next_state;
			if (state == st_strap) strap_cnt <= strap_cnt + 2'h1;
			if (strap_latch) begin
				strap_osc <= sync3[P_OSC];
				strap_boot <= sync3[P_BOOT +: 3];
				rst_cnt <= 20'(RESET_CYCLES - 1);
			end
			if (state == st_ireset && rst_cnt != 20'h00000) rst_cnt <= rst_cnt - 20'h00001;
			if (copy_last) link_cnt <= 2'(`BCS_LINK_EN_CYC - 1);
			else if (state == st_link_dly && link_cnt != 2'h0) link_cnt <= link_cnt - 2'h1; // [R13]
		end
	end

	// clock source and PLL fields
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			osc_sel_ext <= 1'b0;
			pll_f <= `BCS_F_B0;
			pll_r <= `BCS_R_DEF;
			pll_output_divider <= `BCS_OD_B0;
		end else if (ce) begin
			if (strap_latch) begin
				osc_sel_ext <= !sync3[P_OSC]; // [R1]
				pll_f <= def_f; // [R2] [R3]
				pll_r <= `BCS_R_DEF;
				pll_output_divider <= def_od;
			end else if (pll_wr && state != st_strap) begin
				pll_f <= pll_wr_f; // [R5] [R4]
				pll_r <= pll_wr_r;
				pll_output_divider <= pll_wr_od;
			end
		end
	end

	// OTP security load and copy into SRAM
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			otp_rd_en <= 1'b0;
			otp_rd_addr <= 11'h000;
			rd_vld <= 1'b0;
			rd_addr_d <= 11'h000;
			sec_reg <= `BCS_SEC_RESET;
		end else if (ce) begin
			rd_vld <= otp_rd_en;
			rd_addr_d <= otp_rd_addr;
			if (state == st_ireset && rst_cnt == 20'h00000) begin
				otp_rd_en <= 1'b1;
				otp_rd_addr <= `BCS_OTP_SEC_ROW; // [R20] [R21]
			end else if (state == st_sec_rd) begin
				otp_rd_en <= rd_vld;
				otp_rd_addr <= `BCS_OTP_ENTRY;
				if (rd_vld) sec_reg <= otp_rd_data; // [R20]
			end else if (state == st_copy && otp_rd_en) begin
				if (otp_rd_addr == `BCS_OTP_SEC_ROW - 11'h001) otp_rd_en <= 1'b0;
				else otp_rd_addr <= otp_rd_addr + 11'h001;
			end
		end
	end

	// SRAM write port, shared by OTP copy and SPI image
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sram_we <= 1'b0;
			sram_waddr <= 14'h0000;
			sram_wdata <= 32'h0000_0000;
		end else if (ce) begin
			sram_we <= 1'b0;
			if (state == st_copy && rd_vld) begin
				sram_we <= 1'b1; // [R20]
				sram_waddr <= {3'h0, rd_addr_d};
				sram_wdata <= otp_rd_data;
			end else if (spi_done && !spi_hdr && spi_widx[1:0] == 2'h3) begin
				sram_we <= 1'b1;
				sram_waddr <= {2'h0, spi_widx[13:2]};
				sram_wdata <= {spi_word[23:0], spi_rx};
			end
		end
	end

	// SPI boot: read command, zero address, then image bytes
	bcs_spi_xfer u_spi (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.start(spi_go),
		.tx_byte((spi_idx == 14'h0000) ? `BCS_SPI_CMD_READ : 8'h00),
		.miso(pin_q[P_MISO]),
		.sclk(spi_sclk),
		.mosi(spi_mosi),
		.rx_byte(spi_rx),
		.done(spi_done)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			spi_en <= 1'b0;
			spi_ss_n <= 1'b1;
			spi_dual_tile <= 1'b0;
			spi_go <= 1'b0;
			spi_fin <= 1'b0;
			spi_idx <= 14'h0000;
			spi_word <= 32'h0000_0000;
		end else if (ce) begin
			spi_go <= 1'b0;
			if (copy_last && boot_pick == st_spi_run) begin
				spi_en <= 1'b1; // [R11] [R12]
				spi_ss_n <= 1'b0;
				spi_dual_tile <= strap_boot[2]; // [R9]
				spi_go <= 1'b1;
			end
			if (spi_done && !spi_fin) begin
				spi_word <= {spi_word[23:0], spi_rx};
				if (spi_idx == SPI_LAST) begin
					spi_fin <= 1'b1;
					spi_ss_n <= 1'b1;
				end else begin
					spi_idx <= spi_idx + 14'h0001;
					spi_go <= 1'b1;
				end
			end
		end
	end

	// execution start, link boot and security gates
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gpio_pull_en <= 1'b0; // [R7]
			exec_start <= 1'b0;
			exec_from_otp <= 1'b0;
			exec_addr <= `BCS_OTP_ENTRY;
			link_b_en <= 1'b0;
			link_out <= 2'h0;
			link_out_oe <= 1'b0;
			link_pd_en <= 1'b0;
			link_traffic <= 1'b0;
			int_links_en <= 1'b0;
			chan_boot <= 1'b0;
			jtag_grant <= 1'b0;
			sw_grant <= 1'b0;
			debug_req <= 1'b0;
			otp_ext_grant <= 1'b0;
			otp_ext_deny <= 1'b0;
		end else if (ce) begin
			exec_start <= 1'b0;
			link_out <= 2'h0;
			if (state == st_ireset && rst_cnt == 20'h00000) begin
				gpio_pull_en <= 1'b1; // [R8]
				link_pd_en <= 1'b1;
			end
			if (copy_last && boot_pick == st_otp_exec) begin
				exec_start <= 1'b1;
				exec_from_otp <= 1'b1; // [R15]
				exec_addr <= `BCS_OTP_ENTRY;
			end
			if (spi_done && spi_idx == SPI_LAST) exec_start <= 1'b1;
			if (copy_last && boot_pick == st_link_dly) begin
				chan_boot <= strap_boot[2]; // [R9]
				int_links_en <= strap_boot[2];
			end
			if (state == st_link_dly && link_cnt == 2'h0) begin
				link_b_en <= 1'b1; // [R13]
				link_out_oe <= 1'b1;
				link_pd_en <= 1'b0;
			end
			if (state == st_link_run && pin_q[P_LINK +: 2] != 2'h0) link_traffic <= 1'b1; // [R14]
			jtag_grant <= jtag_req && !sec_reg[`BCS_SEC_JTAG_DIS]; // [R16]
			sw_grant <= sw_req && !sec_reg[`BCS_SEC_LINK_DIS]; // [R17]
			debug_req <= boot_live && !pin_q[P_DBG] && !sec_reg[`BCS_SEC_DBG_DIS]; // [R18]
			otp_ext_grant <= otp_ext_req && boot_live && !ext_lock; // [R19]
			otp_ext_deny <= otp_ext_req && (!boot_live || ext_lock);
		end
	end

	property p_osc_sel;
		@(posedge clock) disable iff (!rst_n || !ce) (state == st_ireset) |-> (osc_sel_ext == !strap_osc);
	endproperty
	a_osc_sel: assert property (p_osc_sel) else $error("oscillator select disagrees with strap"); // [R1]

	property p_pll_band;
		@(posedge clock) disable iff (!rst_n || !ce) strap_latch |=> (pll_f == $past(def_f) && pll_r == `BCS_R_DEF);
	endproperty
	a_pll_band: assert property (p_pll_band) else $error("pll default not taken from band"); // [R2]

	property p_pll_wr;
		@(posedge clock) disable iff (!rst_n || !ce)
			(pll_wr && state != st_strap) |=> (pll_output_divider == $past(pll_wr_od) && pll_f == $past(pll_wr_f));
	endproperty
	a_pll_wr: assert property (p_pll_wr) else $error("pll write not applied"); // [R5]

	property p_no_pull;
		@(posedge clock) disable iff (!rst_n || !ce) (state inside {st_strap, st_ireset}) |-> !gpio_pull_en && !spi_en;
	endproperty
	a_no_pull: assert property (p_no_pull) else $error("pins active during internal reset"); // [R8]

	property p_secure;
		@(posedge clock) disable iff (!rst_n || !ce)
			(copy_last && sec_reg[`BCS_SEC_SECURE]) |=> (state == st_otp_exec && exec_start && exec_addr == 11'h000);
	endproperty
	a_secure: assert property (p_secure) else $error("secure boot did not start from otp"); // [R10]

	property p_link_dly;
		@(posedge clock) disable iff (!rst_n || !ce)
			(state == st_link_dly && $past(state) != st_link_dly) |-> !link_b_en ##2 (link_b_en && !link_pd_en);
	endproperty
	a_link_dly: assert property (p_link_dly) else $error("link enable delay wrong"); // [R13]

	property p_jtag;
		@(posedge clock) disable iff (!rst_n || !ce) jtag_grant |-> !$past(sec_reg[`BCS_SEC_JTAG_DIS]);
	endproperty
	a_jtag: assert property (p_jtag) else $error("debug port granted while disabled"); // [R16]

	property p_switch;
		@(posedge clock) disable iff (!rst_n || !ce) sw_grant |-> !$past(sec_reg[`BCS_SEC_LINK_DIS]) && $past(sw_req);
	endproperty
	a_switch: assert property (p_switch) else $error("switch access granted while disabled"); // [R17]

	property p_dbg;
		@(posedge clock) disable iff (!rst_n || !ce) sec_reg[`BCS_SEC_DBG_DIS] |=> !debug_req;
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug request passed while disabled"); // [R18]

	property p_lock;
		@(posedge clock) disable iff (!rst_n || !ce) otp_ext_grant |-> !$past(sec_reg[`BCS_SEC_MLOCK]) && !otp_ext_deny;
	endproperty
	a_lock: assert property (p_lock) else $error("otp access granted under lock"); // [R19]

endmodule : bcs_boot_setup

// ### core/bcs_defines.svh
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

`define BCS_CLK_HZ 10000000
`define BCS_STRAP_LATCH_EDGE 2'd2
`define BCS_RESET_CYCLES 750000
`define BCS_LINK_EN_NS 200
`define BCS_LINK_EN_CYC ((`BCS_LINK_EN_NS * (`BCS_CLK_HZ / 1000000) + 999) / 1000)
`define BCS_SPI_CORE_HZ 400000000
`define BCS_SPI_SCLK_HZ 2500000
`define BCS_SPI_DIV (`BCS_SPI_CORE_HZ / `BCS_SPI_SCLK_HZ)
`define BCS_SPI_CMD_READ 8'h03
`define BCS_SPI_HDR_BYTES 4
`define BCS_SPI_IMAGE_WORDS 256
`define BCS_OTP_SEC_ROW 11'h7ff
`define BCS_OTP_ENTRY 11'h000
`define BCS_SEC_JTAG_DIS 0
`define BCS_SEC_LINK_DIS 1
`define BCS_SEC_DBG_DIS 2
`define BCS_SEC_MLOCK 3
`define BCS_SEC_SECURE 5
`define BCS_SEC_SLOCK_LSB 8
`define BCS_SEC_RESET 32'h0000_0000
`define BCS_F_B0 12'd122
`define BCS_F_B1 12'd119
`define BCS_F_B2 12'd49
`define BCS_F_B3 12'd23
`define BCS_R_DEF 6'd0
`define BCS_OD_B0 3'd1
`define BCS_OD_B123 3'd2

`endif

// ### core/bcs_pkg.sv
package bcs_pkg;

	typedef enum logic [9:0] {
		st_strap = 10'h001,
		st_ireset = 10'h002,
		st_sec_rd = 10'h004,
		st_copy = 10'h008,
		st_jtag_wait = 10'h010,
		st_rsvd = 10'h020,
		st_link_dly = 10'h040,
		st_link_run = 10'h080,
		st_spi_run = 10'h100,
		st_otp_exec = 10'h200
	} bcs_state_type;

endpackage : bcs_pkg

// ### core/bcs_spi_xfer.sv
`include "bcs_defines.svh"
module bcs_spi_xfer
	import bcs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic [7:0] rx_byte,
	output logic done
);
	logic busy;
	logic [6:0] div;
	logic [2:0] bit_cnt;
	logic [7:0] tx_sh;
	wire half_end = (div == 7'(`BCS_SPI_DIV / 2 - 1));

	// mode 0 byte shifter, msb first
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			div <= 7'h00;
			bit_cnt <= 3'h0;
			tx_sh <= 8'h00;
			sclk <= 1'b0;
			mosi <= 1'b0;
			rx_byte <= 8'h00;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (!busy) begin
				div <= 7'h00;
				if (start) begin
					busy <= 1'b1;
					tx_sh <= tx_byte;
					mosi <= tx_byte[7];
					bit_cnt <= 3'h0;
				end
			end else if (half_end) begin
				div <= 7'h00;
				sclk <= !sclk;
				if (!sclk) begin
					rx_byte <= {rx_byte[6:0], miso};
				end else if (bit_cnt == 3'h7) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					bit_cnt <= bit_cnt + 3'h1;
					tx_sh <= {tx_sh[6:0], 1'b0};
					mosi <= tx_sh[6];
				end
			end else begin
				div <= div + 7'h01;
			end
		end
	end

endmodule : bcs_spi_xfer

// ### verif/bcs_boot_setup_test.sv
module bcs_boot_setup_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RC = 20;
	localparam logic [63:0] IMG = 64'h1234_5678_9abc_def0;
	logic clock = 0, rst_n = 0, ce = 1, osc_ext_n_pin = 0, freq_strap_lo = 0, freq_strap_hi = 0;
	logic [2:0] boot_src_strap = 0, pll_output_divider, pll_wr_od = 0;
	logic [11:0] pll_f, pll_wr_f = 0;
	logic [5:0] pll_r, pll_wr_r = 0;
	logic [10:0] otp_rd_addr, exec_addr, otp_ext_addr = 0;
	logic [31:0] otp_rd_data = 0, sram_wdata, sec_reg, cmd, sec_val = 0;
	logic [13:0] sram_waddr;
	logic [1:0] link_out, link_in;
	logic osc_sel_ext, pll_wr = 0, gpio_pull_en, otp_rd_en, sram_we, exec_start, exec_from_otp;
	logic jtag_req = 0, jtag_grant, sw_req = 0, sw_grant, debug_n_pin = 1, debug_req;
	logic otp_ext_req = 0, otp_ext_grant, otp_ext_deny, spi_en, spi_ss_n, spi_sclk, spi_mosi, spi_miso;
	logic spi_dual_tile, link_b_en, link_out_oe, link_pd_en, link_traffic, int_links_en, chan_boot, go = 0;
	int seed = 40, n_errors = 0, total_checks = 0, cyc = 0, wcount = 0, n_exec = 0, k, n;
	logic [31:0] exp_q[$];

	bcs_boot_setup #(.RESET_CYCLES(RC), .SPI_IMAGE_WORDS(2)) i_dut (
		.clock, .rst_n, .ce, .osc_ext_n_pin, .freq_strap_lo, .freq_strap_hi, .boot_src_strap,
		.osc_sel_ext, .pll_f, .pll_r, .pll_output_divider, .pll_wr, .pll_wr_f, .pll_wr_r, .pll_wr_od,
		.gpio_pull_en, .otp_rd_en, .otp_rd_addr, .otp_rd_data, .sram_we, .sram_waddr, .sram_wdata,
		.sec_reg, .exec_start, .exec_from_otp, .exec_addr, .jtag_req, .jtag_grant, .sw_req, .sw_grant,
		.debug_n_pin, .debug_req, .otp_ext_req, .otp_ext_addr, .otp_ext_grant, .otp_ext_deny,
		.spi_en, .spi_ss_n, .spi_sclk, .spi_mosi, .spi_miso, .spi_dual_tile, .link_b_en, .link_out,
		.link_out_oe, .link_pd_en, .link_in, .link_traffic, .int_links_en, .chan_boot
	);
	bcs_flash_link #(.IMAGE(IMG)) i_mem (
		.clock, .spi_ss_n, .spi_sclk, .spi_mosi, .link_out_oe, .go, .spi_miso, .link_in, .cmd
	);

	always #50 clock = ~clock;

	function automatic logic [31:0] pat(input logic [10:0] a);
		return {a, 10'h0, a};
	endfunction : pat

	function automatic logic [20:0] band(input logic [1:0] b);
		case (b)
			2'b00: return {12'd122, 6'd0, 3'd1};
			2'b01: return {12'd119, 6'd0, 3'd2};
			2'b10: return {12'd49, 6'd0, 3'd2};
			default: return {12'd23, 6'd0, 3'd2};
		endcase
	endfunction : band

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	always @(posedge clock) begin
		cyc++;
		otp_rd_data <= (otp_rd_addr == 11'h7ff) ? sec_val : pat(otp_rd_addr);
		if (!rst_n) begin
			wcount <= 0;
			n_exec <= 0;
		end else begin
			if (exec_start)
				n_exec <= n_exec + 1;
			if (sram_we) begin
				chk(sram_waddr, wcount < 2047 ? wcount : wcount - 2047, "sram addr");
				if (exp_q.size() == 0)
					chk(sram_we, 0, "unexpected sram write");
				else
					chk(sram_wdata, exp_q.pop_front(), "sram data");
				wcount <= wcount + 1;
			end
		end
		if (cyc == 90000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic boot(input logic [2:0] m, input logic [31:0] s);
		logic [20:0] b, w, v;
		logic ln, sp, lk;
		ln = !s[5] && m[1:0] == 2'b10;
		sp = !s[5] && m[1:0] == 2'b11;
		exp_q.delete();
		for (int i = 0; i < 2047; i++)
			exp_q.push_back(pat(11'(i)));
		if (sp) begin
			exp_q.push_back(IMG[63:32]);
			exp_q.push_back(IMG[31:0]);
		end
		@(posedge clock);
		rst_n <= 0;
		sec_val <= s;
		boot_src_strap <= m;
		go <= 0;
		osc_ext_n_pin <= $random(seed);
		freq_strap_lo <= $random(seed);
		freq_strap_hi <= $random(seed);
		otp_ext_req <= 1;
		otp_ext_addr <= $random(seed);
		jtag_req <= 0;
		sw_req <= 0;
		debug_n_pin <= 1;
		repeat (16) @(posedge clock);
		chk({gpio_pull_en, link_out_oe, spi_en, spi_ss_n}, 4'b0001, "pins in reset");
		rst_n <= 1;
		repeat (6) @(posedge clock); // straps held past third edge
		b = band({freq_strap_hi, freq_strap_lo});
		chk(osc_sel_ext, !osc_ext_n_pin, "osc select");
		chk({pll_f, pll_r, pll_output_divider}, b, "band pll");
		freq_strap_lo <= !freq_strap_lo;
		n = 6;
		while (gpio_pull_en !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk(n >= RC && n <= RC + 6, 1, "reset length");
		chk(otp_ext_deny, 1, "otp before boot");
		n = 0;
		while (wcount < 2047 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		repeat (6) @(posedge clock);
		chk(sec_reg, s, "security row");
		chk({pll_f, pll_r, pll_output_divider}, b, "strap latch");
		chk({exec_from_otp, spi_en, spi_dual_tile, link_b_en, link_out_oe, link_pd_en, chan_boot, int_links_en},
			{s[5], sp, sp & m[2], ln, ln, !ln, ln & m[2], ln & m[2]}, "boot source");
		chk({link_out, link_traffic}, 0, "link idle");
		if (ln) begin
			go <= 1;
			repeat (10) @(posedge clock);
			chk(link_traffic, 1, "link traffic");
		end
		if (sp) begin
			n = 0;
			while (n_exec == 0 && n < 20000) begin
				@(posedge clock);
				n++;
			end
			repeat (4) @(posedge clock);
			chk(cmd, 32'h0300_0000, "spi command");
			chk({spi_ss_n, 14'(wcount)}, {1'b1, 14'd2049}, "spi words");
		end
		repeat (4) @(posedge clock);
		chk(n_exec, s[5] | sp, "exec start");
		chk(exp_q.size(), 0, "sram words left");
		if (s[5]) begin
			chk(exec_addr, 0, "entry address");
			jtag_req <= 1;
			sw_req <= 1;
			debug_n_pin <= 0;
			repeat (8) @(posedge clock);
			lk = s[3] | s[8 + otp_ext_addr[10:9]];
			chk({jtag_grant, sw_grant, debug_req, otp_ext_grant, otp_ext_deny},
				{!s[0], !s[1], !s[2], !lk, lk}, "security");
		end
		w = $random(seed); // any value fits the field widths
		v = $random(seed);
		pll_wr <= 1;
		{pll_wr_f, pll_wr_r, pll_wr_od} <= w;
		@(posedge clock);
		{pll_wr_f, pll_wr_r, pll_wr_od} <= v;
		@(posedge clock);
		chk({pll_f, pll_r, pll_output_divider}, w, "pll write 1");
		pll_wr <= 0;
		@(posedge clock);
		chk({pll_f, pll_r, pll_output_divider}, v, "pll write 2");
		$display("boot test mode %0d sec %0h done", m, s);
	endtask : boot

	initial begin
		for (k = 0; k < 8; k++)
			boot(k[2:0], 32'h0);
		boot($random(seed), 32'h20 | ($random(seed) & 32'h0f0f));
		boot(3'b011, 32'h20);
		finish_test();
	end
endmodule : bcs_boot_setup_test

// ### verif/bcs_flash_link.sv
module bcs_flash_link #(
	parameter logic [63:0] IMAGE = 64'h0
) (
	input wire logic clock,
	input wire logic spi_ss_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	input wire logic link_out_oe,
	input wire logic go,
	output logic spi_miso,
	output logic [1:0] link_in,
	output logic [31:0] cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cnt = 7'h00;
	logic sclk_q = 1'b0;
	initial spi_miso = 1'b0;
	initial cmd = 32'h0;
	always @(posedge clock) begin
		sclk_q <= spi_sclk;
		if (spi_ss_n) begin
			cnt <= 7'h00;
			spi_miso <= ~spi_miso;
		end else if (spi_sclk && !sclk_q) begin
			cnt <= cnt + 7'h01;
			if (cnt < 7'd32)
				cmd <= {cmd[30:0], spi_mosi};
		end else if (!spi_sclk && sclk_q && cnt >= 7'd32 && cnt < 7'd96) begin
			spi_miso <= IMAGE[95 - cnt];
		end
	end
	// wires pulled low until traffic starts after link enable
	assign link_in = (link_out_oe && go) ? 2'b01 : 2'b00;
endmodule : bcs_flash_link
